// ### include/vic_pkg.sv
package vic_pkg;
	// register map, byte addresses on the Avalon-MM slave
	localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h0b;
	localparam logic [7:0] ADDR_CTRL_CONVERTER = 8'h1e;
	localparam logic [7:0] ADDR_CORE_CTRL = 8'h40;
	// primary control fields
	localparam int BIT_GLOBAL_EN = 0;
	localparam int BIT_EXT_EN = 1;
	localparam int BIT_TA_EN = 2;
	localparam int BIT_TB_EN = 3;
	localparam int BIT_EXT_FLAG = 4;
	localparam int BIT_TA_FLAG = 5;
	localparam int BIT_TB_FLAG = 6;
	localparam int BIT_TEST = 7;
	// converter control fields
	localparam int BIT_CONV_EN = 0;
	localparam int BIT_CONV_FLAG = 4;
	// reset values
	localparam logic [7:0] RESET_PRIMARY = 8'h00;
	localparam logic [1:0] RESET_CONVERTER = 2'h0;
	// vectors
	localparam logic [7:0] VEC_EXT = 8'h04;
	localparam logic [7:0] VEC_TA = 8'h08;
	localparam logic [7:0] VEC_TB = 8'h0c;
	localparam logic [7:0] VEC_CONV = 8'h10;
	localparam logic [7:0] VEC_NONE = 8'h00;
	// external edge selection
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam int STACK_DEPTH = 4;

	typedef struct packed {
		logic ext_pin;
		logic timer_a_ovf;
		logic timer_b_ovf;
		logic conv_done;
		logic porta_fall;
		logic wdt_ovf;
	} vic_src_t;

	typedef struct packed {
		logic cycle_phase_two;
		logic return_from_irq_instr;
		logic plain_return_instr;
		logic [2:0] stack_pointer;
		logic low_power;
	} vic_core_in_t;

	typedef struct packed {
		logic call_req;
		logic [7:0] call_vector;
		logic push_pc;
		logic wake;
	} vic_core_out_t;
endpackage

// ### verilog/vic_controller.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - primary bits 0-3: global and source enables
// - primary bits 4-6: external, timer flags
// - converter register: enable bit0, flag bit4
// - masked requests still set their flags
// - software re-enable allows nesting unless full
// - full stack blocks every acknowledge
// - every source can wake device
// - acknowledge pushes only pc, then branches
// - external edge chosen by build option
// - external ack: vector 04, clear flag, global
// - timer a ack: vector 08, clear both
// - timer b ack: vector 0c, clear both
// - converter ack: vector 10, clear both
// - irq return sets global; plain return not
// - requests sampled at phase-two pulse
// - fixed priority external, ta, tb, converter
// - flags stay until serviced or cleared
// - wake on irq, port fall, wdt, timer flag
// - status register is never saved automatically
module vic_controller
	import vic_pkg::*;
#(
	parameter logic [1:0] EXT_EDGE = EDGE_FALL,
	parameter int DEPTH = STACK_DEPTH
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// interrupt sources; external, port and watchdog are asynchronous pins
	input wire vic_src_t src_in,
	// core sequencer
	input wire vic_core_in_t core_in,
	output vic_core_out_t core_out
);

	// ============================================================
	// state
	typedef struct packed {
		logic [2:0] ext_sync;
		logic ext_last;
		logic [2:0] pa_sync;
		logic [2:0] wdt_sync;
		logic ta_last;
		logic tb_last;
		logic cv_last;
		logic [7:0] primary;
		logic conv_en;
		logic conv_flag;
		logic bus_done;
		logic [31:0] rdata;
		vic_core_out_t out;
	} vic_state_t;

	vic_state_t state_reg;
	vic_state_t state_next;

	// ============================================================
	// helpers
	function automatic logic edge_hit(input logic prev, input logic cur);
		unique case (EXT_EDGE)
			EDGE_RISE: edge_hit = !prev && cur;
			EDGE_BOTH: edge_hit = prev != cur;
			default: edge_hit = prev && !cur;
		endcase
	endfunction

	function automatic logic hit(input logic [7:0] a);
		hit = avs_address == a;
	endfunction

	logic ext_stable;
	logic ext_evt;
	logic pa_fall;
	logic wdt_level;
	logic ta_evt;
	logic tb_evt;
	logic cv_evt;
	logic stack_full;
	logic [3:0] pending;
	logic [3:0] grant;
	logic wr_pri;
	logic wr_cnv;
	logic access;

	// ============================================================
	// synchronised pin edges
	// second and third stage must agree before a level counts
	always_comb begin
		ext_stable = state_reg.ext_sync[1] == state_reg.ext_sync[2];
		ext_evt = ext_stable &&
			edge_hit(state_reg.ext_last, state_reg.ext_sync[2]);
		pa_fall = state_reg.pa_sync[2] && !state_reg.pa_sync[1];
		// watchdog overflow comes from its own oscillator domain
		wdt_level = state_reg.wdt_sync[2] && state_reg.wdt_sync[1];
		// overflow and done inputs come from same-clock logic
		ta_evt = src_in.timer_a_ovf && !state_reg.ta_last;
		tb_evt = src_in.timer_b_ovf && !state_reg.tb_last;
		cv_evt = src_in.conv_done && !state_reg.cv_last;
	end

	// ============================================================
	// arbitration
	always_comb begin
		stack_full = core_in.stack_pointer >= 3'(DEPTH);
		pending[0] = state_reg.primary[BIT_EXT_FLAG] &&
			state_reg.primary[BIT_EXT_EN];
		pending[1] = state_reg.primary[BIT_TA_FLAG] &&
			state_reg.primary[BIT_TA_EN];
		pending[2] = state_reg.primary[BIT_TB_FLAG] &&
			state_reg.primary[BIT_TB_EN];
		pending[3] = state_reg.conv_flag && state_reg.conv_en;
		grant = 4'h0;
		// global enable gate; re-enabling inside a handler nests
		if (state_reg.primary[BIT_GLOBAL_EN] && !stack_full &&
			core_in.cycle_phase_two && !state_reg.out.call_req) begin
			if (pending[0]) begin
				grant = 4'h1;
			end else if (pending[1]) begin
				grant = 4'h2;
			end else if (pending[2]) begin
				grant = 4'h4;
			end else if (pending[3]) begin
				grant = 4'h8;
			end
		end
	end

	// ============================================================
	// next state
	always_comb begin
		state_next = state_reg;
		access = (avs_read || avs_write) && !state_reg.bus_done;
		// writes land only at the edge that ends the wait state
		wr_pri = avs_write && state_reg.bus_done &&
			hit(ADDR_CTRL_PRIMARY);
		wr_cnv = avs_write && state_reg.bus_done &&
			hit(ADDR_CTRL_CONVERTER);
		state_next.ext_sync = {state_reg.ext_sync[1:0], src_in.ext_pin};
		state_next.pa_sync = {state_reg.pa_sync[1:0], src_in.porta_fall};
		state_next.wdt_sync = {state_reg.wdt_sync[1:0],
			src_in.wdt_ovf};
		if (ext_stable) begin
			state_next.ext_last = state_reg.ext_sync[2];
		end
		state_next.ta_last = src_in.timer_a_ovf;
		state_next.tb_last = src_in.timer_b_ovf;
		state_next.cv_last = src_in.conv_done;

		// software write first; hardware events override below
		if (wr_pri) begin
			state_next.primary = avs_writedata[7:0];
		end
		if (wr_cnv) begin
			state_next.conv_en = avs_writedata[BIT_CONV_EN];
			state_next.conv_flag = avs_writedata[BIT_CONV_FLAG];
		end
		if (core_in.return_from_irq_instr) begin
			state_next.primary[BIT_GLOBAL_EN] = 1'b1;
		end
		// acknowledge clears the granted flag and global enable
		if (grant != 4'h0) begin
			state_next.primary[BIT_GLOBAL_EN] = 1'b0;
		end
		if (grant[0]) begin
			state_next.primary[BIT_EXT_FLAG] = 1'b0;
		end
		if (grant[1]) begin
			state_next.primary[BIT_TA_FLAG] = 1'b0;
		end
		if (grant[2]) begin
			state_next.primary[BIT_TB_FLAG] = 1'b0;
		end
		if (grant[3]) begin
			state_next.conv_flag = 1'b0;
		end
		// flags set regardless of masks; set beats any clear
		if (ext_evt) begin
			state_next.primary[BIT_EXT_FLAG] = 1'b1;
		end
		if (ta_evt) begin
			state_next.primary[BIT_TA_FLAG] = 1'b1;
		end
		if (tb_evt) begin
			state_next.primary[BIT_TB_FLAG] = 1'b1;
		end
		if (cv_evt) begin
			state_next.conv_flag = 1'b1;
		end

		// core outputs: pc push and vector only, no status save
		state_next.out.call_req = grant != 4'h0;
		state_next.out.push_pc = grant != 4'h0;
		unique case (1'b1)
			grant[0]: state_next.out.call_vector = VEC_EXT;
			grant[1]: state_next.out.call_vector = VEC_TA;
			grant[2]: state_next.out.call_vector = VEC_TB;
			grant[3]: state_next.out.call_vector = VEC_CONV;
			default: state_next.out.call_vector = VEC_NONE;
		endcase
		// any flag-raising or wake event wakes without enables; a standing flag wakes only if enabled
		state_next.out.wake = core_in.low_power &&
			(ext_evt || ta_evt || tb_evt || cv_evt || pa_fall ||
			wdt_level || (pending != 4'h0));

		// bus: answer one cycle after the request appears
		state_next.bus_done = access;
		state_next.rdata = 32'h0;
		if (access && avs_read) begin
			if (hit(ADDR_CTRL_PRIMARY)) begin
				state_next.rdata = {24'h0, state_reg.primary};
			end else if (hit(ADDR_CTRL_CONVERTER)) begin
				state_next.rdata = {27'h0, state_reg.conv_flag, 3'h0,
					state_reg.conv_en};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= '0;
			// pin idles high; a low reset value would fake an edge
			state_reg.ext_sync <= 3'h7;
			state_reg.ext_last <= 1'h1;
			state_reg.primary <= RESET_PRIMARY;
			state_reg.conv_en <= RESET_CONVERTER[0];
			state_reg.conv_flag <= RESET_CONVERTER[1];
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		avs_waitrequest = (avs_read || avs_write) && !state_reg.bus_done;
		avs_readdata = state_reg.rdata;
		core_out = state_reg.out;
	end

	// ============================================================
	// checks
	chk_no_ack_full: assert property (
		@(posedge clk_sys) disable iff (reset)
		stack_full |-> grant == 4'h0)
		else $error("acknowledge while stack full");
	chk_ack_clears_ge: assert property (
		@(posedge clk_sys) disable iff (reset)
		(grant != 4'h0 && !core_in.return_from_irq_instr) |=>
		!state_reg.primary[BIT_GLOBAL_EN] && core_out.call_req)
		else $error("acknowledge did not clear global enable");
	chk_ext_vector: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[0] |=> core_out.call_vector == VEC_EXT)
		else $error("wrong external vector");
	chk_conv_vector: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[3] |=> core_out.call_vector == VEC_CONV &&
		!$past(pending[0]))
		else $error("wrong converter vector or priority");
	chk_mask_blocks: assert property (
		@(posedge clk_sys) disable iff (reset)
		!state_reg.primary[BIT_GLOBAL_EN] |=> !core_out.call_req)
		else $error("acknowledge while globally masked");
	chk_phase_only: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_out.call_req |-> $past(core_in.cycle_phase_two))
		else $error("acknowledge outside phase pulse");
	chk_return_from_irq_instr_sets: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_in.return_from_irq_instr && grant == 4'h0 |=>
		state_reg.primary[BIT_GLOBAL_EN])
		else $error("irq return did not set global enable");
	chk_flag_sticky: assert property (
		@(posedge clk_sys) disable iff (reset)
		state_reg.primary[BIT_TA_FLAG] && !grant[1] && !wr_pri |=>
		state_reg.primary[BIT_TA_FLAG])
		else $error("timer a flag lost");
	chk_conv_rsvd: assert property (
		@(posedge clk_sys) disable iff (reset)
		$past(access && avs_read && hit(ADDR_CTRL_CONVERTER)) |->
		avs_readdata[3:1] == 3'h0 && avs_readdata[7:5] == 3'h0)
		else $error("converter reserved bits not zero");
	chk_wake_timer: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_in.low_power && ta_evt |=> core_out.wake)
		else $error("timer flag did not wake");
	chk_ta_vector: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[1] |=> core_out.call_vector == VEC_TA)
		else $error("wrong timer a vector");
	chk_tb_vector: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[2] |=> core_out.call_vector == VEC_TB)
		else $error("wrong timer b vector");
	chk_ext_clear: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[0] && !ext_evt |=>
		!state_reg.primary[BIT_EXT_FLAG])
		else $error("external flag not cleared on acknowledge");
	chk_ta_clear: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[1] && !ta_evt |=>
		!state_reg.primary[BIT_TA_FLAG])
		else $error("timer a flag not cleared on acknowledge");
	chk_conv_clear: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[3] && !cv_evt |=> !state_reg.conv_flag)
		else $error("converter flag not cleared on acknowledge");
	chk_ext_sets: assert property (
		@(posedge clk_sys) disable iff (reset)
		ext_evt |=> state_reg.primary[BIT_EXT_FLAG])
		else $error("external edge did not set its flag");
	chk_ta_sets: assert property (
		@(posedge clk_sys) disable iff (reset)
		ta_evt |=> state_reg.primary[BIT_TA_FLAG])
		else $error("timer a overflow did not set its flag");
	chk_conv_sets: assert property (
		@(posedge clk_sys) disable iff (reset)
		cv_evt |=> state_reg.conv_flag)
		else $error("conversion done did not set its flag");
	chk_sw_set_req: assert property (
		@(posedge clk_sys) disable iff (reset)
		wr_pri && avs_writedata[BIT_EXT_FLAG] && !grant[0] |=>
		state_reg.primary[BIT_EXT_FLAG])
		else $error("software set of external flag lost");
	chk_take_gates: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_out.call_req |->
		$past(state_reg.primary[BIT_GLOBAL_EN]) && !$past(stack_full))
		else $error("acknowledge without global enable");
	chk_one_call: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_out.call_req |=> !core_out.call_req)
		else $error("call request longer than one cycle");
	chk_push_pairs: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_out.push_pc == core_out.call_req)
		else $error("pc push not paired with call");
	chk_idle_vector: assert property (
		@(posedge clk_sys) disable iff (reset)
		!core_out.call_req |-> core_out.call_vector == VEC_NONE)
		else $error("vector shown without call");
	chk_ret_keeps: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_in.plain_return_instr && !core_in.return_from_irq_instr &&
		grant == 4'h0 && !wr_pri |=>
		state_reg.primary[BIT_GLOBAL_EN] ==
		$past(state_reg.primary[BIT_GLOBAL_EN]))
		else $error("plain return changed global enable");
	chk_prio_ext: assert property (
		@(posedge clk_sys) disable iff (reset)
		pending[0] && grant != 4'h0 |-> grant[0])
		else $error("external request lost priority");
	chk_prio_conv: assert property (
		@(posedge clk_sys) disable iff (reset)
		grant[3] |-> pending[2:0] == 3'h0)
		else $error("converter granted over higher source");
	chk_phase_gate: assert property (
		@(posedge clk_sys) disable iff (reset)
		!core_in.cycle_phase_two |-> grant == 4'h0)
		else $error("grant outside phase pulse");
	chk_pri_read: assert property (
		@(posedge clk_sys) disable iff (reset)
		$past(access && avs_read && hit(ADDR_CTRL_PRIMARY)) |->
		avs_readdata == {24'h0, $past(state_reg.primary)})
		else $error("primary register read back wrong");
	chk_wake_lp: assert property (
		@(posedge clk_sys) disable iff (reset)
		!core_in.low_power |=> !core_out.wake)
		else $error("wake outside low power");
	chk_wake_wdt: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_in.low_power && wdt_level |=> core_out.wake)
		else $error("watchdog overflow did not wake");
	chk_wake_pending: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_in.low_power && pending != 4'h0 |=> core_out.wake)
		else $error("pending request did not wake");
	chk_wake_port: assert property (
		@(posedge clk_sys) disable iff (reset)
		core_in.low_power && pa_fall |=> core_out.wake)
		else $error("port fall did not wake");
endmodule

// ### verification/vic_core_model.sv
`timescale 1ns/1ps
module vic_core_model
	import vic_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// controller side
	input wire vic_core_out_t core_out,
	output vic_core_in_t core_in,
	// bench commands
	input wire logic return_from_irq_instr_cmd,
	input wire logic ret_cmd,
	input wire logic lp_cmd,
	input wire logic depth_load,
	input wire logic [2:0] depth_val
);
	// ==========================================
	// sequencer and return stack
	logic [1:0] ph_reg;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ph_reg <= 2'h0;
			core_in <= '0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			// one phase pulse per four-clock machine cycle
			core_in.cycle_phase_two <= ph_reg == 2'h3;
			core_in.return_from_irq_instr <= return_from_irq_instr_cmd;
			core_in.plain_return_instr <= ret_cmd;
			core_in.low_power <= lp_cmd;
			// only acknowledges push; handlers make no calls
			if (depth_load)
				core_in.stack_pointer <= depth_val;
			else if (core_out.push_pc)
				core_in.stack_pointer <= core_in.stack_pointer + 3'h1;
			else if ((return_from_irq_instr_cmd || ret_cmd) && core_in.stack_pointer != 3'h0)
				core_in.stack_pointer <= core_in.stack_pointer - 3'h1;
		end
	end
endmodule

// ### verification/test_vectored_interrupt_controller.sv
`timescale 1ns/1ps
module test_vectored_interrupt_controller;
	import vic_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	// ext_pin and porta_fall idle high
	vic_src_t src = 6'h22;
	vic_core_in_t core_in;
	vic_core_out_t core_out;
	logic return_from_irq_instr_cmd = 1'b0;
	logic ret_cmd = 1'b0;
	logic lp_cmd = 1'b0;
	logic depth_load = 1'b0;
	logic [2:0] depth_val = 3'h0;
	logic [7:0] rd;
	logic [7:0] vec_order [4] = '{VEC_EXT, VEC_TA, VEC_TB, VEC_CONV};
	int n_fail = 0;
	int checked = 0;

	always #10 clk_sys = ~clk_sys;

	vic_controller vic_controller_i (.clk_sys(clk_sys), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.src_in(src), .core_in(core_in), .core_out(core_out));
	vic_core_model vic_core_model_i (.clk_sys(clk_sys), .reset(reset),
		.core_out(core_out), .core_in(core_in), .return_from_irq_instr_cmd(return_from_irq_instr_cmd),
		.ret_cmd(ret_cmd), .lp_cmd(lp_cmd), .depth_load(depth_load),
		.depth_val(depth_val));

	// ==========================================
	// shared tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata[7:0];
		if (n >= 20) begin
			n_fail++;
			give_verdict();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk({24'h0, rd}, {24'h0, e});
	endtask

	// VEC_NONE means no call may come within lim cycles
	task automatic call_chk(input logic [7:0] v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (core_out.call_req !== 1'b1 && n < lim);
		if (v == VEC_NONE)
			chk({31'h0, core_out.call_req}, 32'h0);
		else
			chk({23'h0, core_out.push_pc, core_out.call_vector}, {24'h1, v});
	endtask

	task automatic ret_pulse(input logic irq);
		@(posedge clk_sys);
		return_from_irq_instr_cmd <= irq;
		ret_cmd <= !irq;
		@(posedge clk_sys);
		return_from_irq_instr_cmd <= 1'b0;
		ret_cmd <= 1'b0;
	endtask

	// the pin filter drops a low shorter than two cycles
	task automatic src_pulse(input logic [5:0] m, input int len);
		@(posedge clk_sys);
		src <= src ^ m;
		repeat (len) @(posedge clk_sys);
		src <= src ^ m;
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		rd_chk(ADDR_CTRL_PRIMARY, 8'h00);
		rd_chk(ADDR_CTRL_CONVERTER, 8'h00);
		bus(1'b1, 8'h20, 8'hff);
		rd_chk(8'h20, 8'h00);
		bus(1'b1, ADDR_CTRL_PRIMARY, 8'h0e);
		rd_chk(ADDR_CTRL_PRIMARY, 8'h0e);
		bus(1'b1, ADDR_CTRL_CONVERTER, 8'hff);
		rd_chk(ADDR_CTRL_CONVERTER, 8'h11);
		bus(1'b1, ADDR_CTRL_CONVERTER, 8'h00);
	endtask

	task automatic t_ext();
		src_pulse(6'h20, 3);
		call_chk(VEC_NONE, 12);
		rd_chk(ADDR_CTRL_PRIMARY, 8'h1e);
		bus(1'b1, ADDR_CTRL_PRIMARY, 8'h1f);
		call_chk(VEC_EXT, 20);
		rd_chk(ADDR_CTRL_PRIMARY, 8'h0e);
		ret_pulse(1'b1);
		rd_chk(ADDR_CTRL_PRIMARY, 8'h0f);
		bus(1'b1, ADDR_CTRL_PRIMARY, 8'h0e);
		ret_pulse(1'b0);
		rd_chk(ADDR_CTRL_PRIMARY, 8'h0e);
	endtask

	// global enable comes back through an irq return, not a write,
	// so the hardware-set flags are not touched by software
	task automatic t_priority();
		int i;
		bus(1'b1, ADDR_CTRL_CONVERTER, 8'h01);
		src_pulse(6'h3c, 3);
		repeat (6) @(posedge clk_sys);
		ret_pulse(1'b1);
		for (i = 0; i < 4; i++) begin
			call_chk(vec_order[i], 20);
			ret_pulse(1'b1);
		end
		rd_chk(ADDR_CTRL_PRIMARY, 8'h0f);
		rd_chk(ADDR_CTRL_CONVERTER, 8'h01);
	endtask

	task automatic t_stack();
		@(posedge clk_sys);
		depth_val <= 3'h2;
		depth_load <= 1'b1;
		@(posedge clk_sys);
		depth_load <= 1'b0;
		src_pulse(6'h10, 1);
		call_chk(VEC_TA, 20);
		src_pulse(6'h08, 1);
		bus(1'b1, ADDR_CTRL_PRIMARY, 8'h4f);
		call_chk(VEC_TB, 20);
		bus(1'b1, ADDR_CTRL_PRIMARY, 8'h2f);
		call_chk(VEC_NONE, 16);
		rd_chk(ADDR_CTRL_PRIMARY, 8'h2f);
		ret_pulse(1'b0);
		call_chk(VEC_TA, 20);
	endtask

	task automatic t_wake();
		int i;
		int n;
		logic [5:0] m [4] = '{6'h10, 6'h02, 6'h01, 6'h04};
		bus(1'b1, ADDR_CTRL_PRIMARY, 8'h00);
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			lp_cmd <= 1'b1;
			repeat (6) @(posedge clk_sys);
			chk({31'h0, core_out.wake}, 32'h0);
			src <= src ^ m[i];
			// a timer or port event wakes for one cycle only, so watch for it
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (core_out.wake !== 1'b1 && n < 8);
			chk({31'h0, core_out.wake}, 32'h1);
			src <= 6'h22;
			lp_cmd <= 1'b0;
			bus(1'b1, ADDR_CTRL_PRIMARY, 8'h00);
			bus(1'b1, ADDR_CTRL_CONVERTER, 8'h01);
		end
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_ext();
		t_priority();
		t_stack();
		t_wake();
		give_verdict();
	end
endmodule
